// *** logic/adc_digital_port.sv ***
// Operation
// - Disable pin high floats all data outputs
// - Disable pin low drives data outputs unless the software disable bit is set
// - Sleep request high enters low power
// - Span select high 2Vp-p, low 1Vp-p unless the software span bit is set
// - Reference select high external, low internal unless the software reference bit is set
// - Word on ten pins, msb down lsb
// - Unconnected control inputs read as low
// - Output word updates on rising clock edge
// - Result appears five clocks after sampling
`timescale 1ns/10ps
module adc_digital_port (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Static control pins
  input wire logic output_disable_i,
  input wire logic sleep_request_i,
  input wire logic input_span_select_i,
  input wire logic reference_source_select_i,
  // Quantizer code, two's complement, one per clock
  input wire logic [9:0] raw_code_i,
  // Data pins, bit 9 is sample_msb and bit 0 is sample_lsb
  output logic [9:0] sample_o,
  output logic [9:0] sample_oe_o,
  // Analog front-end controls
  output logic low_power_o,
  output logic span_2vpp_o,
  output logic ref_external_o
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic [3:0] ctrl;
    logic [3:0] applied;
    logic [4:0][9:0] pipe;
    logic [2:0] fill;
    logic [9:0] sample;
    logic [9:0] sample_oe;
    logic overflow;
    logic ack;
    logic [31:0] rdata;
  } port_state_t;

  port_state_t s_reg;
  port_state_t s_next;

  // Capture buffer handshake
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [9:0] fifo_out_data;
  logic [3:0] pins;
  logic bus_hit;
  logic [31:0] status_word;

  // ****************************************************************
  // Pins and bus decode
  // ****************************************************************
  assign pins = {reference_source_select_i, input_span_select_i,
                 sleep_request_i, output_disable_i};

  // A new request is taken only while no answer is pending
  assign bus_hit = wb_cyc_i && wb_stb_i && !s_reg.ack;

  // A word is captured each advancing edge once the pipe holds real samples
  // Words are dropped, not stalled, when software lags: the converter never waits
  assign fifo_in_valid = !s_reg.applied[adc_port_pkg::CTL_SLEEP]
                         && (s_reg.fill == adc_port_pkg::FILL_FULL);

  // Reading the data register drains one word
  assign fifo_out_ready = bus_hit && !wb_we_i && (wb_adr_i == adc_port_pkg::REG_DATA);

  // Status view of the block's own state, each flag at its package position
  always_comb begin
    status_word = 32'h00000000;
    status_word[adc_port_pkg::CTL_W-1:0] = s_reg.applied;
    status_word[adc_port_pkg::ST_EMPTY_N] = fifo_out_valid;
    status_word[adc_port_pkg::ST_FULL] = !fifo_in_ready;
    status_word[adc_port_pkg::ST_OVERFLOW] = s_reg.overflow;
    status_word[adc_port_pkg::ST_PRIMED] = (s_reg.fill == adc_port_pkg::FILL_FULL);
  end

  // ****************************************************************
  // Capture buffer
  // ****************************************************************
  sample_fifo #(
    .WIDTH(adc_port_pkg::SAMPLE_W),
    .DEPTH(adc_port_pkg::FIFO_DEPTH)
  ) u_capture_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(s_reg.pipe[adc_port_pkg::LATENCY-1]),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_next = s_reg;
    // Two-stage synchroniser on the static pins
    // Only pin_sync is read further on; pin_meta may still be settling
    s_next.pin_meta = pins;
    s_next.pin_sync = s_reg.pin_meta;

    // low default levels
    // A pin or a software bit can only assert a control; both rest low,
    // so an undriven pin (pulled down on the pad) leaves normal operation.
    s_next.applied = s_reg.pin_sync | s_reg.ctrl;

    s_next.sample_oe = {adc_port_pkg::SAMPLE_W{!s_next.applied[adc_port_pkg::CTL_DISABLE]}};

    // hold pipe asleep
    // Asleep the pipe and the pins freeze; the last word stays visible.
    if (!s_reg.applied[adc_port_pkg::CTL_SLEEP]) begin
      s_next.pipe[0] = raw_code_i ^ adc_port_pkg::SIGN_FLIP;
      for (int i = 1; i < adc_port_pkg::LATENCY; i++) begin
        s_next.pipe[i] = s_reg.pipe[i-1];
      end
      s_next.sample = s_reg.pipe[adc_port_pkg::LATENCY-1];
      if (s_reg.fill != adc_port_pkg::FILL_FULL) begin
        s_next.fill = s_reg.fill + 3'h1;
      end
    end

    // Bus answer is one cycle after the request, dropped the next cycle
    s_next.ack = bus_hit;
    if (bus_hit) begin
      s_next.rdata = 32'h00000000;
      if (wb_we_i) begin
        if (wb_adr_i == adc_port_pkg::REG_CTRL && wb_sel_i[0]) begin
          s_next.ctrl = wb_dat_i[3:0];
        end
      end else begin
        case (wb_adr_i)
          adc_port_pkg::REG_CTRL: s_next.rdata = {28'h0000000, s_reg.ctrl};
          adc_port_pkg::REG_STATUS: s_next.rdata = status_word;
          adc_port_pkg::REG_DATA: begin
            s_next.rdata[adc_port_pkg::DATA_VALID_BIT] = fifo_out_valid;
            s_next.rdata[9:0] = fifo_out_valid ? fifo_out_data : 10'h000;
          end
          default: s_next.rdata = 32'h00000000;
        endcase
      end
    end

    // Overflow is sticky; a new loss in the clearing cycle wins
    s_next.overflow = (s_reg.overflow
                       && !(bus_hit && wb_we_i && wb_sel_i[0]
                            && wb_adr_i == adc_port_pkg::REG_STATUS
                            && wb_dat_i[adc_port_pkg::ST_OVERFLOW]))
                      || (fifo_in_valid && !fifo_in_ready);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Reset zeroes control, so outputs float until the first enabled edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign wb_dat_o = s_reg.rdata;
  assign wb_ack_o = s_reg.ack;
  assign sample_o = s_reg.sample;
  assign sample_oe_o = s_reg.sample_oe;
  assign low_power_o = s_reg.applied[adc_port_pkg::CTL_SLEEP];
  assign span_2vpp_o = s_reg.applied[adc_port_pkg::CTL_SPAN];
  assign ref_external_o = s_reg.applied[adc_port_pkg::CTL_REF];

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Software disable reaches every data pin enable within one edge
  chk_disable_floats: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && s_reg.ctrl[adc_port_pkg::CTL_DISABLE])[*2] |-> sample_oe_o == 10'h000)
    else $error("Data pins still driven while disabled");

  // No disable request from either source leaves all pins driven
  chk_enable_drives: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !s_reg.ctrl[adc_port_pkg::CTL_DISABLE]
     && !s_reg.pin_sync[adc_port_pkg::CTL_DISABLE])[*2]
    |-> sample_oe_o == 10'h3ff)
    else $error("Data pins not driven while enabled");

  // A software sleep request reaches the low-power output
  chk_sleep_enters: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && s_reg.ctrl[adc_port_pkg::CTL_SLEEP])[*2] |-> low_power_o)
    else $error("Low power not entered on sleep request");

  // Asleep, the data word does not move
  chk_sleep_holds: assert property (
    @(posedge clk_i) disable iff (rst_i)
    low_power_o && !$past(rst_i) |=> $stable(sample_o))
    else $error("Data word changed while asleep");

  // Span select follows the combined request
  chk_span_follows: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && !$past(rst_i) |=> span_2vpp_o
      == ($past(s_reg.ctrl[adc_port_pkg::CTL_SPAN])
          | $past(s_reg.pin_sync[adc_port_pkg::CTL_SPAN])))
    else $error("Span select not applied");

  // A software reference request selects the external reference
  chk_ref_follows: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && s_reg.ctrl[adc_port_pkg::CTL_REF])[*2] |-> ref_external_o)
    else $error("External reference not selected");

  // Right after reset every control rests low
  chk_reset_low: assert property (
    @(posedge clk_i)
    $past(rst_i) && !rst_i |-> s_reg.ctrl == 4'h0 && !low_power_o)
    else $error("Control not low after reset");

  // Word changes only at an enabled, awake edge
  chk_edge_update: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && $changed(sample_o) |-> $past(ce_i) && !$past(low_power_o))
    else $error("Data word changed without an enabled edge");

  // Sample taken at one edge shows on the pins five edges later, msb first
  chk_five_latency: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !low_power_o)[*6] ##1 1'b1
    |-> sample_o == ($past(raw_code_i, 6) ^ adc_port_pkg::SIGN_FLIP))
    else $error("Pipeline delay is not five clocks");

  // Most negative input gives the all-zero word
  chk_offset_binary: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !low_power_o)[*6] ##1 ($past(raw_code_i, 6) == adc_port_pkg::NEG_FULL_CODE)
    |-> sample_o == 10'h000)
    else $error("Negative full scale not coded as zero");

  // The disable pin reaches every data pin enable through the synchroniser
  chk_pin_floats: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && s_reg.pin_sync[adc_port_pkg::CTL_DISABLE])[*2] |-> sample_oe_o == 10'h000)
    else $error("Data pins still driven while the disable pin is high");

  // With no sleep request from either source the converter keeps running
  chk_awake_runs: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !s_reg.ctrl[adc_port_pkg::CTL_SLEEP]
     && !s_reg.pin_sync[adc_port_pkg::CTL_SLEEP])[*2] |-> !low_power_o)
    else $error("Low power held without a sleep request");

  // Internal reference whenever neither source asks for the external one
  chk_ref_internal: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !s_reg.ctrl[adc_port_pkg::CTL_REF]
     && !s_reg.pin_sync[adc_port_pkg::CTL_REF])[*2] |-> !ref_external_o)
    else $error("External reference selected without a request");

  // The sign of the taken code lands inverted on the top data pin
  chk_msb_position: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !low_power_o)[*6] ##1 1'b1
    |-> sample_o[9] == !$past(raw_code_i[9], 6))
    else $error("Most significant bit not on the top data pin");

  // A taken request is answered at the next edge
  chk_ack_taken: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("Bus request not answered at the next edge");

  // The answer stands for a single enabled cycle
  chk_ack_single: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("Bus answer held for more than one cycle");

endmodule : adc_digital_port

// *** logic/adc_port_pkg.sv ***
// ****************************************************************
// Shared constants for the converter digital port
// ****************************************************************
package adc_port_pkg;

  // Sample word and pipeline
  localparam int SAMPLE_W = 10;
  localparam int LATENCY = 5;
  localparam int FILL_W = 3;
  localparam logic [2:0] FILL_FULL = 3'h5;
  // Offset binary: flipping the sign bit of a two's complement code
  localparam logic [9:0] SIGN_FLIP = 10'h200;
  localparam logic [9:0] NEG_FULL_CODE = 10'h200;

  // Capture buffer
  localparam int FIFO_DEPTH = 8;

  // Register bus
  localparam int ADR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;

  // Control bit positions (also used for pins and applied levels)
  localparam int CTL_DISABLE = 0;
  localparam int CTL_SLEEP = 1;
  localparam int CTL_SPAN = 2;
  localparam int CTL_REF = 3;
  localparam int CTL_W = 4;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Status bit positions
  localparam int ST_EMPTY_N = 4;
  localparam int ST_FULL = 5;
  localparam int ST_OVERFLOW = 6;
  localparam int ST_PRIMED = 7;

  // Data register layout
  localparam int DATA_VALID_BIT = 31;

endpackage : adc_port_pkg

// *** logic/sample_fifo.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Small synchronous FIFO held in flip-flops
// ****************************************************************
module sample_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t s_reg;
  fifo_state_t s_next;
  logic push;
  logic pop;

  // Depth must be a power of two so that pointers wrap by themselves
  assign in_ready_o = (s_reg.cnt != (AW + 1)'(DEPTH));
  assign out_valid_o = (s_reg.cnt != '0);
  assign out_data_o = s_reg.mem[s_reg.rd];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_ready_i && out_valid_o;

  // Next state: write at the tail, read at the head
  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wr] = in_data_i;
      s_next.wr = s_reg.wr + 1'b1;
    end
    if (pop) begin
      s_next.rd = s_reg.rd + 1'b1;
    end
    case ({push, pop})
      2'b10: s_next.cnt = s_reg.cnt + 1'b1;
      2'b01: s_next.cnt = s_reg.cnt - 1'b1;
      default: s_next.cnt = s_reg.cnt;
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else if (ce_i) begin
      s_reg <= s_next;
    end
  end

endmodule : sample_fifo

// *** bench/host_capture.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Host capture register watching the ten data pins
// ****************************************************************
module host_capture (
  // Clock and pins
  input wire logic clk_i,
  input wire logic [9:0] sample_i,
  input wire logic [9:0] sample_oe_i,
  // Captured word and float flag
  output logic [9:0] word_o,
  output logic floating_o
);
  logic [9:0] last_reg = 10'h0;
  logic [9:0] wire_level;

  // No pull on these lines, so a released bit shows the inverse of its last level
  assign wire_level = (sample_i & sample_oe_i) | (~last_reg & ~sample_oe_i);

  always_ff @(posedge clk_i) begin
    last_reg <= wire_level;
    word_o <= wire_level;
    floating_o <= ~&sample_oe_i;
  end
endmodule : host_capture

// *** bench/testbench.sv ***
`timescale 1ns/10ps
// ****************************************************************
// Self-checking bench for the converter digital port
// ****************************************************************
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [3:0] pins = 4'h0;
  logic ce = 1'b1;
  logic [3:0] sel = 4'hf;
  logic [9:0] raw_code_i = 10'h0;
  logic [9:0] sample_o;
  logic [9:0] sample_oe_o;
  logic low_power_o;
  logic span_2vpp_o;
  logic ref_external_o;
  logic [9:0] host_word;
  logic host_floating;
  logic [31:0] rd;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;

  // Clock at 50 MHz
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  adc_digital_port dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .output_disable_i(pins[0]),
    .sleep_request_i(pins[1]), .input_span_select_i(pins[2]),
    .reference_source_select_i(pins[3]), .raw_code_i(raw_code_i), .sample_o(sample_o),
    .sample_oe_o(sample_oe_o), .low_power_o(low_power_o), .span_2vpp_o(span_2vpp_o),
    .ref_external_o(ref_external_o));

  host_capture host (.clk_i(clk_i), .sample_i(sample_o), .sample_oe_i(sample_oe_o),
    .word_o(host_word), .floating_o(host_floating));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Classic cycle: request held until ack is sampled, then idle one cycle
  // Only the hang guard ends a wait for the answer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  function automatic logic [9:0] code(input int i);
    return (i == 0) ? 10'h200 : (i == 1) ? 10'h1ff : 10'(i * 67);
  endfunction : code

  task automatic finish_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      finish_test();
    end
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b0, adc_port_pkg::REG_CTRL, 32'h0);
    check(rd, 32'h0);
    bus(1'b0, 8'h0c, 32'h0);
    check(rd, 32'h0);
    // A write without its low byte lane leaves control untouched
    sel <= 4'he;
    bus(1'b1, adc_port_pkg::REG_CTRL, 32'hf);
    sel <= 4'hf;
    bus(1'b0, adc_port_pkg::REG_CTRL, 32'h0);
    check(rd, 32'h0);
    check({ref_external_o, span_2vpp_o, low_power_o}, 32'h0);
    $display("test reset done");
    // Extremes of the code range go first
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_i);
      raw_code_i <= code(i);
      #1;
      if (i >= 6) check(sample_o, code(i - 6) ^ 10'h200);
      if (i >= 7) check(host_word, code(i - 7) ^ 10'h200);
    end
    @(posedge clk_i);
    // Clock enable low freezes the pipe, which then resumes where it stopped
    ce <= 1'b0;
    repeat (8) @(posedge clk_i);
    check(sample_o, code(10) ^ 10'h200);
    ce <= 1'b1;
    repeat (2) @(posedge clk_i);
    check(sample_o, code(11) ^ 10'h200);
    $display("test latency done");
    // Each control first by register, then by pin
    for (int b = 0; b < 8; b++) begin
      pins <= (b >= 4) ? 4'(1 << (b - 4)) : 4'h0;
      bus(1'b1, adc_port_pkg::REG_CTRL, (b < 4) ? 32'(1 << b) : 32'h0);
      repeat (4) @(posedge clk_i);
      check({ref_external_o, span_2vpp_o, low_power_o, sample_oe_o === 10'h0},
        32'(1 << (b % 4)));
      check(host_floating, b % 4 == 0);
      bus(1'b0, adc_port_pkg::REG_STATUS, 32'h0);
      check(rd[3:0], 32'(1 << (b % 4)));
    end
    pins <= 4'h0;
    bus(1'b1, adc_port_pkg::REG_CTRL, 32'h0);
    repeat (4) @(posedge clk_i);
    check(sample_oe_o, 32'h3ff);
    $display("test controls done");
    // Sleep freezes the pipe so the buffer can be drained
    raw_code_i <= 10'h155;
    repeat (10) @(posedge clk_i);
    bus(1'b1, adc_port_pkg::REG_CTRL, 32'h2);
    for (int i = 0; i < 12; i++) bus(1'b0, adc_port_pkg::REG_DATA, 32'h0);
    bus(1'b1, adc_port_pkg::REG_STATUS, 32'h40);
    bus(1'b0, adc_port_pkg::REG_STATUS, 32'h0);
    check(rd[6:4], 32'h0);
    bus(1'b1, adc_port_pkg::REG_CTRL, 32'h0);
    repeat (20) @(posedge clk_i);
    bus(1'b1, adc_port_pkg::REG_CTRL, 32'h2);
    bus(1'b0, adc_port_pkg::REG_STATUS, 32'h0);
    // Full buffer is also not empty, and the drops since waking set overflow
    check(rd[6:4], 32'h7);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, adc_port_pkg::REG_DATA, 32'h0);
      check(rd, 32'h8000_0355);
    end
    bus(1'b0, adc_port_pkg::REG_DATA, 32'h0);
    check(rd[31], 32'h0);
    bus(1'b0, adc_port_pkg::REG_STATUS, 32'h0);
    // Drained and empty, but the overflow flag is sticky until cleared
    check(rd[6:4], 32'h4);
    $display("test buffer done");
    finish_test();
  end
endmodule : testbench
